// [afz_pkg.sv]
/*
  afz_pkg: register indices, reset values, field layouts and the zone/apb-response
  carrier structs of the automatic fan zone-limit block.
  assumes: an APB slave with 32-bit data; registers sit one per aligned word.
*/
package afz_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_MIN_DUTY_1   = 8'h64;
  localparam logic [7:0] IDX_MIN_DUTY_2   = 8'h65;
  localparam logic [7:0] IDX_MIN_DUTY_3   = 8'h66;
  localparam logic [7:0] IDX_LOW_LIMIT_1  = 8'h67;
  localparam logic [7:0] IDX_LOW_LIMIT_2  = 8'h68;
  localparam logic [7:0] IDX_LOW_LIMIT_3  = 8'h69;
  localparam logic [7:0] IDX_ABS_LIMIT_1  = 8'h6a;
  localparam logic [7:0] IDX_ABS_LIMIT_2  = 8'h6b;
  localparam logic [7:0] IDX_ABS_LIMIT_3  = 8'h6c;
  localparam logic [7:0] IDX_TEST_A       = 8'h6d;
  localparam logic [7:0] IDX_TEST_B       = 8'h6e;
  localparam logic [7:0] IDX_CONTROL      = 8'h80;
  localparam logic [7:0] IDX_STATUS       = 8'h81;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_MIN_DUTY     = 8'h80;
  localparam logic [7:0] RST_LOW_LIMIT    = 8'h80;
  localparam logic [7:0] RST_ABS_LIMIT    = 8'h64;
  localparam logic [7:0] RST_TEST_A       = 8'h44;
  localparam logic [7:0] RST_TEST_B       = 8'h40;
  localparam logic [7:0] ABS_DISABLED     = 8'h80;
  localparam logic [7:0] TEST_B_WR_MASK   = 8'hf0;
  localparam logic [7:0] DUTY_FULL        = 8'hff;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int CTL_LOCK_BIT   = 0;
  localparam int CTL_AUTO_LSB   = 1;
  localparam int CTL_DIS_LSB    = 4;
  localparam int CTL_RANGE_LSB  = 8;
  localparam int RANGE_W        = 4;
  localparam int NUM_FANS       = 3;

  // last pwm count; period is 255 sys_clk cycles (one duty step per cycle)
  localparam logic [7:0] PWM_LAST_STEP = 8'hfe;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] min_duty;
    logic [7:0] low_limit;
    logic [7:0] abs_limit;
  } afz_zone_t;

  typedef struct packed {
    logic [7:0] prdata;
    logic       pready;
  } afz_apb_rsp_t;

endpackage : afz_pkg

// [afz_zone_limits.sv]
/*
  afz_zone_limits: zone limit / minimum duty registers and the automatic
  duty computation for three fan outputs, with absolute-limit override.
  assumes: zone temperatures arrive synchronous to sys_clk as signed degrees;
  supply_power_good rises once per main-supply power-on.
*/
`timescale 1ns/1ps

module afz_zone_limits #(
  parameter int NUM_ZONES = 3
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 supply_power_good_i,
  input  wire logic [NUM_ZONES*8-1:0] zone_temp_i,
  input  wire logic [NUM_ZONES*8-1:0] manual_duty_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic [31:0]               prdata_o,
  output logic                      fan_output_1_o,
  output logic                      fan_output_2_o,
  output logic                      fan_output_3_o,
  output logic                      full_speed_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    afz_pkg::afz_zone_t [NUM_ZONES-1:0] zone;
    logic [7:0]                         test_a;
    logic [7:0]                         test_b;
    logic                               lock;
    logic [NUM_ZONES-1:0]               auto_en;
    logic [NUM_ZONES-1:0]               disabled;
    logic [NUM_ZONES*4-1:0]             range;
    logic [NUM_ZONES*8-1:0]             duty;
    logic                               override;
    logic [7:0]                         pwm_cnt;
    logic [NUM_ZONES-1:0]               pwm;
    logic                               pg_prev;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
  } afz_state_t;

  afz_state_t state_reg;
  afz_state_t state_next;

  // range code to whole degrees, fractional entries rounded up
  function automatic logic [7:0] range_deg(input logic [3:0] code);
    logic [7:0] r;
    r = 8'h02;
    unique case (code)
      4'h0: r = 8'h02;
      4'h1: r = 8'h03;
      4'h2: r = 8'h04;
      4'h3: r = 8'h04;
      4'h4: r = 8'h05;
      4'h5: r = 8'h07;
      4'h6: r = 8'h08;
      4'h7: r = 8'h0a;
      4'h8: r = 8'h0e;
      4'h9: r = 8'h10;
      4'ha: r = 8'h14;
      4'hb: r = 8'h1b;
      4'hc: r = 8'h20;
      4'hd: r = 8'h28;
      4'he: r = 8'h36;
      4'hf: r = 8'h50;
    endcase
    return r;
  endfunction : range_deg

  // automatic duty for one zone; signed compare of limits
  function automatic logic [7:0] auto_duty(
    input logic [7:0] temp,
    input logic [7:0] low,
    input logic [7:0] mind,
    input logic [3:0] code
  );
    logic signed [9:0] diff;
    logic [7:0]        rng;
    logic [16:0]       prod;
    logic [7:0]        d;
    diff = 10'(signed'(temp)) - 10'(signed'(low));
    rng  = range_deg(code);
    prod = {9'h000, 8'hff - mind} * {9'h000, diff[7:0]};
    d    = 8'h00;
    if (diff < 10'sd0)
    begin
      d = 8'h00;
    end
    else if (diff >= signed'({2'b00, rng}))
    begin
      d = afz_pkg::DUTY_FULL;
    end
    else
    begin
      d = mind + 8'(prod / 17'(rng));
    end
    return d;
  endfunction : auto_duty

  logic       wr_en;
  logic       rd_en;
  logic [9:0] idx;
  logic       hit;
  logic [7:0] rd_byte;
  logic       any_abs;

  assign idx   = paddr_i[11:2];
  assign wr_en = psel_i && penable_i && pwrite_i && !state_reg.pready;
  assign rd_en = psel_i && penable_i && !pwrite_i && !state_reg.pready;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    hit        = 1'b1;
    rd_byte    = 8'h00;
    any_abs    = 1'b0;

    // one-wait-state apb answer
    state_next.pready  = psel_i && penable_i && !state_reg.pready;
    state_next.pslverr = 1'b0;

    for (int z = 0; z < NUM_ZONES; z++)
    begin
      if (state_reg.zone[z].abs_limit != afz_pkg::ABS_DISABLED &&
          signed'(zone_temp_i[z*8 +: 8]) > signed'(state_reg.zone[z].abs_limit))
      begin
        any_abs = 1'b1;
      end
    end
    state_next.override = any_abs && (|state_reg.auto_en);

    for (int f = 0; f < NUM_ZONES; f++)
    begin
      if (state_reg.disabled[f])
      begin
        state_next.duty[f*8 +: 8] = 8'h00;
      end
      else if (state_reg.override)
      begin
        state_next.duty[f*8 +: 8] = afz_pkg::DUTY_FULL;
      end
      else if (state_reg.auto_en[f])
      begin
        state_next.duty[f*8 +: 8] = auto_duty(zone_temp_i[f*8 +: 8],
                                              state_reg.zone[f].low_limit,
                                              state_reg.zone[f].min_duty,
                                              state_reg.range[f*4 +: 4]);
      end
      else
      begin
        state_next.duty[f*8 +: 8] = manual_duty_i[f*8 +: 8];
      end
      // ffh is held high all period; 00h never high
      state_next.pwm[f] = (state_reg.duty[f*8 +: 8] == afz_pkg::DUTY_FULL) ||
                          (state_reg.pwm_cnt < state_reg.duty[f*8 +: 8]);
    end
    state_next.pwm_cnt = (state_reg.pwm_cnt == afz_pkg::PWM_LAST_STEP) ?
                         8'h00 : state_reg.pwm_cnt + 8'h01;

    unique case (idx[7:0])
      afz_pkg::IDX_MIN_DUTY_1:  rd_byte = state_reg.zone[0].min_duty;
      afz_pkg::IDX_MIN_DUTY_2:  rd_byte = state_reg.zone[1].min_duty;
      afz_pkg::IDX_MIN_DUTY_3:  rd_byte = state_reg.zone[2].min_duty;
      afz_pkg::IDX_LOW_LIMIT_1: rd_byte = state_reg.zone[0].low_limit;
      afz_pkg::IDX_LOW_LIMIT_2: rd_byte = state_reg.zone[1].low_limit;
      afz_pkg::IDX_LOW_LIMIT_3: rd_byte = state_reg.zone[2].low_limit;
      afz_pkg::IDX_ABS_LIMIT_1: rd_byte = state_reg.zone[0].abs_limit;
      afz_pkg::IDX_ABS_LIMIT_2: rd_byte = state_reg.zone[1].abs_limit;
      afz_pkg::IDX_ABS_LIMIT_3: rd_byte = state_reg.zone[2].abs_limit;
      afz_pkg::IDX_TEST_A:      rd_byte = state_reg.test_a;
      afz_pkg::IDX_TEST_B:      rd_byte = state_reg.test_b;
      afz_pkg::IDX_CONTROL:     rd_byte = 8'h00;
      afz_pkg::IDX_STATUS:      rd_byte = {4'h0, state_reg.override, state_reg.pwm};
      default:                  hit     = 1'b0;
    endcase
    if (idx[9:8] != 2'b00)
    begin
      hit = 1'b0;
    end

    if (rd_en)
    begin
      state_next.prdata = 32'h0;
      if (idx[7:0] == afz_pkg::IDX_CONTROL && hit)
      begin
        state_next.prdata = {12'h000, state_reg.range, 1'b0, state_reg.disabled,
                             state_reg.auto_en, state_reg.lock};
      end
      else
      begin
        state_next.prdata = {24'h0, rd_byte};
      end
      state_next.pslverr = !hit;
    end

    if (wr_en)
    begin
      state_next.pslverr = !hit;
      if (!state_reg.lock)
      begin
        unique case (idx[7:0])
          afz_pkg::IDX_MIN_DUTY_1:  state_next.zone[0].min_duty  = pwdata_i[7:0];
          afz_pkg::IDX_MIN_DUTY_2:  state_next.zone[1].min_duty  = pwdata_i[7:0];
          afz_pkg::IDX_MIN_DUTY_3:  state_next.zone[2].min_duty  = pwdata_i[7:0];
          afz_pkg::IDX_LOW_LIMIT_1: state_next.zone[0].low_limit = pwdata_i[7:0];
          afz_pkg::IDX_LOW_LIMIT_2: state_next.zone[1].low_limit = pwdata_i[7:0];
          afz_pkg::IDX_LOW_LIMIT_3: state_next.zone[2].low_limit = pwdata_i[7:0];
          afz_pkg::IDX_ABS_LIMIT_1: state_next.zone[0].abs_limit = pwdata_i[7:0];
          afz_pkg::IDX_ABS_LIMIT_2: state_next.zone[1].abs_limit = pwdata_i[7:0];
          afz_pkg::IDX_ABS_LIMIT_3: state_next.zone[2].abs_limit = pwdata_i[7:0];
          afz_pkg::IDX_TEST_A:      state_next.test_a = pwdata_i[7:0];
          afz_pkg::IDX_TEST_B:      state_next.test_b = pwdata_i[7:0] & afz_pkg::TEST_B_WR_MASK;
          afz_pkg::IDX_CONTROL:
          begin
            // lock is sticky until reset: software cannot unlock
            state_next.lock     = pwdata_i[afz_pkg::CTL_LOCK_BIT];
            state_next.auto_en  = pwdata_i[afz_pkg::CTL_AUTO_LSB +: NUM_ZONES];
            state_next.disabled = pwdata_i[afz_pkg::CTL_DIS_LSB +: NUM_ZONES];
            state_next.range    = pwdata_i[afz_pkg::CTL_RANGE_LSB +: NUM_ZONES*4];
          end
          default:                  state_next.lock = state_reg.lock;
        endcase
      end
    end

    // power-good rising edge reloads low limits, beating any write
    state_next.pg_prev = supply_power_good_i;
    if (supply_power_good_i && !state_reg.pg_prev)
    begin
      for (int z = 0; z < NUM_ZONES; z++)
      begin
        state_next.zone[z].low_limit = afz_pkg::RST_LOW_LIMIT;
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= '0;
      for (int z = 0; z < NUM_ZONES; z++)
      begin
        state_reg.zone[z].min_duty  <= afz_pkg::RST_MIN_DUTY;
        state_reg.zone[z].low_limit <= afz_pkg::RST_LOW_LIMIT;
        state_reg.zone[z].abs_limit <= afz_pkg::RST_ABS_LIMIT;
      end
      state_reg.test_a <= afz_pkg::RST_TEST_A;
      state_reg.test_b <= afz_pkg::RST_TEST_B;
      state_reg.range  <= '1;
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
    end
  end

  assign pready_o       = state_reg.pready;
  assign pslverr_o      = state_reg.pslverr;
  assign prdata_o       = state_reg.prdata;
  assign fan_output_1_o = state_reg.pwm[0];
  assign fan_output_2_o = state_reg.pwm[1];
  assign fan_output_3_o = state_reg.pwm[2];
  assign full_speed_o   = state_reg.override;

endmodule : afz_zone_limits

// [afz_zone_limits_assertions.sv]
/*
  checker: bus answer timing, freeze and override cause at the top ports.
  assumes: bound onto afz_zone_limits, one clock, sync reset.
*/
`timescale 1ns/1ps
module afz_chk #(
  parameter int NUM_ZONES = 3
) (
  input wire logic                   sys_clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   clk_en_i,
  input wire logic [NUM_ZONES*8-1:0] zone_temp_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire logic [31:0]            prdata_o,
  input wire logic                   fan_output_1_o,
  input wire logic                   fan_output_2_o,
  input wire logic                   fan_output_3_o,
  input wire logic                   full_speed_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  logic cold;
  always_comb
  begin
    cold = 1'b1;
    for (int z = 0; z < NUM_ZONES; z++)
      cold &= (zone_temp_i[8*z+:8] inside {8'h80, 8'h81});
  end
  sequence s_acc;
    psel_i && penable_i && !pready_o && clk_en_i;
  endsequence
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  ready_one_wait_a: assert property (s_acc |=> pready_o)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready_o && clk_en_i |=> !pready_o)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property ($rose(pready_o) |-> $past(psel_i && penable_i))
    else $error("ready without access");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_hold_a: assert property ($changed(prdata_o) |-> pready_o)
    else $error("read data moved without answer");
  reset_quiet_a: assert property ($fell(sys_rst_i) |-> !pready_o && !full_speed_o
    && !fan_output_1_o && !fan_output_2_o && !fan_output_3_o)
    else $error("outputs not quiet after reset");
  freeze_a: assert property (!clk_en_i |=> $stable({pready_o, pslverr_o, prdata_o,
    fan_output_1_o, fan_output_2_o, fan_output_3_o, full_speed_o}))
    else $error("state moved while frozen");
  cold_override_a: assert property ((cold && clk_en_i)[*3] |=> !full_speed_o)
    else $error("override with no zone above -127");
endmodule : afz_chk

bind afz_zone_limits afz_chk #(.NUM_ZONES(NUM_ZONES)) afz_chk_i (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .zone_temp_i(zone_temp_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
  .fan_output_1_o(fan_output_1_o), .fan_output_2_o(fan_output_2_o),
  .fan_output_3_o(fan_output_3_o), .full_speed_o(full_speed_o));

// [afz_fan_sensor_model.sv]
/*
  far side: zone sensors and a duty meter per fan over 255-cycle windows.
  assumes: sensors update once a clock; pwm period is 255 cycles.
*/
`timescale 1ns/1ps
module afz_fan_sensor_model (
  input  wire logic        sys_clk_i,
  input  wire logic [2:0]  fan_i,
  input  wire logic [23:0] temp_set_i,
  output logic [23:0]      zone_temp_o,
  output logic [2:0][8:0]  high_cnt_o,
  output logic             win_done_o
);
  logic [2:0][8:0] acc = '0;
  int              step = 0;
  initial zone_temp_o = '0;
  initial win_done_o = 1'b0;
  // sensors lag one cycle, as a real reading register would
  always @(posedge sys_clk_i)
  begin
    zone_temp_o <= temp_set_i;
    for (int f = 0; f < 3; f++)
    begin
      if (step == 254)
        high_cnt_o[f] <= acc[f] + 9'(fan_i[f]);
      acc[f] <= (step == 254) ? 9'h000 : acc[f] + 9'(fan_i[f]);
    end
    step <= (step == 254) ? 0 : step + 1;
    win_done_o <= (step == 254);
  end
endmodule : afz_fan_sensor_model

// [afz_zone_limits_tb.sv]
/*
  testbench: register model, duty model and override checks.
  assumes: fan f on zone f, duty counted over one 255-cycle window.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module afz_zone_limits_tb;
  logic sys_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, supply_power_good_i = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, win_done;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [23:0] zone_temp_i, temp_set = '0, manual_duty_i = '0;
  logic pready_o, pslverr_o, fan_output_1_o, fan_output_2_o, fan_output_3_o, full_speed_o;
  logic [2:0][8:0] hi_cnt;
  int failures = 0, samples_checked = 0, rnd = 43, mreg[int];
  int rg[16] = '{2, 3, 4, 4, 5, 7, 8, 10, 14, 16, 20, 27, 32, 40, 54, 80};
  afz_zone_limits #(.NUM_ZONES(3)) afz_zone_limits_i (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .supply_power_good_i(supply_power_good_i),
    .zone_temp_i(zone_temp_i), .manual_duty_i(manual_duty_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .fan_output_1_o(fan_output_1_o), .fan_output_2_o(fan_output_2_o),
    .fan_output_3_o(fan_output_3_o), .full_speed_o(full_speed_o));
  afz_fan_sensor_model afz_fan_sensor_model_i (.sys_clk_i(sys_clk_i),
    .fan_i({fan_output_3_o, fan_output_2_o, fan_output_1_o}), .temp_set_i(temp_set),
    .zone_temp_o(zone_temp_i), .high_cnt_o(hi_cnt), .win_done_o(win_done));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  function automatic int xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  // auto duty, range already rounded up to whole degrees
  function automatic int duty(int t, int lo, int mn, int c);
    if (t < lo)
      return 0;
    if (t >= lo + rg[c])
      return 255;
    return mn + (255 - mn) * (t - lo) / rg[c];
  endfunction : duty
  task automatic apb(input bit wr, input int idx, input int wd, output logic [31:0] rd,
                     output logic err);
    int n = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= 12'(idx * 4);
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1 && ++n < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50)
      failures++;
  endtask : apb
  task automatic wr(input int idx, input int v);
    logic [31:0] r;
    logic e;
    apb(1, idx, v, r, e);
    if (mreg[8'h80][0] == 0)
      mreg[idx] = (idx == 8'h80) ? v & 32'hfff7f : (idx == 8'h6e) ? v & 8'hf0 : v & 8'hff;
  endtask : wr
  task automatic rd_chk(input int idx);
    logic [31:0] r;
    logic e;
    apb(0, idx, 0, r, e);
    `CHK("reg", 32'(mreg[idx]), r)
    `CHK("slverr", 1'b0, e)
  endtask : rd_chk
  task automatic meas(input int d1, input int d2, input int d3, input logic fs);
    repeat (3) @(posedge win_done);
    #1;
    `CHK("fan1", 9'(d1), hi_cnt[0])
    `CHK("fan2", 9'(d2), hi_cnt[1])
    `CHK("fan3", 9'(d3), hi_cnt[2])
    `CHK("full", fs, full_speed_o)
  endtask : meas
  task automatic print_verdict();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    failures++;
    print_verdict();
  end
  initial
  begin
    logic [31:0] r;
    logic e;
    int mn, md;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 8'h64; i <= 8'h6e; i++)
      mreg[i] = (i < 8'h6a) ? 8'h80 : (i < 8'h6d) ? 8'h64 : (i == 8'h6d) ? 8'h44 : 8'h40;
    mreg[8'h80] = 32'h000fff00;
    for (int i = 8'h64; i <= 8'h6e; i++)
      rd_chk(i);
    rd_chk(8'h80);
    apb(0, 8'h90, 0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    for (int i = 8'h64; i <= 8'h6e; i++)
    begin
      wr(i, xs());
      rd_chk(i);
    end
    for (int i = 8'h6a; i <= 8'h6c; i++)
      wr(i, 8'h7f);
    mn = xs() & 8'hff;
    md = xs() & 8'hff;
    wr(8'h64, mn);
    wr(8'h67, 8'hce);
    manual_duty_i <= {8'h00, 8'(md), 8'h00};
    // fan1 auto, fan2 manual, fan3 disabled
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h80, 32'h42 | (c << 8));
      temp_set <= {16'h0000, 8'(-51 + rg[c])};
      meas(duty(-51 + rg[c], -50, mn, c), md, 0, 0);
    end
    wr(8'h80, 32'h242);
    foreach (rg[k])
      if (k < 3)
      begin
        temp_set <= {16'h0000, 8'(k * 4 - 54 + (k == 0 ? 3 : 0))};
        meas(duty(k * 4 - 54 + (k == 0 ? 3 : 0), -50, mn, 2), md, 0, 0);
      end
    wr(8'h6c, 8'h32);
    temp_set <= {8'd51, 8'h00, 8'hcd};
    meas(255, 255, 0, 1);
    wr(8'h6c, 8'h80);
    temp_set <= {8'h7f, 8'h00, 8'hcd};
    meas(0, md, 0, 0);
    // all zones near -128: zone 3 above its 80h limit must still not force full speed
    temp_set <= {8'h81, 8'h80, 8'h81};
    meas(0, md, 0, 0);
    clk_en_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    wr(8'h67, 8'h11);
    wr(8'h68, 8'h22);
    supply_power_good_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (int i = 8'h67; i <= 8'h69; i++)
    begin
      mreg[i] = 8'h80;
      rd_chk(i);
    end
    wr(8'h80, 32'h243);
    for (int i = 8'h64; i <= 8'h6c; i++)
    begin
      wr(i, xs());
      rd_chk(i);
    end
    wr(8'h80, 0);
    rd_chk(8'h80);
    print_verdict();
  end
endmodule : afz_zone_limits_tb
